// ==== common/acr_pkg.sv ====
// constants, register map and state type of the converter control block
package acr_pkg;
    // register byte addresses
    localparam logic [7:0] CTL_OFFSET = 8'h00;
    localparam logic [7:0] TRG_OFFSET = 8'h04;
    localparam logic [7:0] CFG_OFFSET = 8'h08;
    localparam logic [7:0] INTF_OFFSET = 8'h0c;
    localparam logic [7:0] INTE_OFFSET = 8'h10;
    localparam logic [7:0] RESULT_BASE = 8'h20;
    localparam logic [2:0] RESULT_REGION = 3'h1;
    // control register fields
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_START_BIT = 1;
    localparam int CTL_BUSY_BIT = 10;
    localparam int CTL_STATUS_LSB = 12;
    // trigger and input select fields, then the range field and the overwrite flag offset
    localparam int TRG_SMP_LSB = 0;
    localparam int TRG_SRC_LSB = 4;
    localparam int TRG_MODE_BIT = 6;
    localparam int TRG_ALIGN_BIT = 7;
    localparam int TRG_FIRST_LSB = 8;
    localparam int TRG_LAST_LSB = 11;
    localparam int CFG_RANGE_LSB = 0;
    localparam int OVERWRITE_LSB = 8;
    // reset values
    localparam logic ENABLE_RESET = 1'b0;
    localparam logic START_RESET = 1'b0;
    localparam logic [2:0] INPUT_RESET = 3'h0;
    localparam logic ALIGN_RESET = 1'b0;
    localparam logic MODE_RESET = 1'b0;
    localparam logic [1:0] SRC_RESET = 2'h0;
    localparam logic [2:0] SMP_RESET = 3'h7;
    localparam logic [1:0] RANGE_RESET = 2'h0;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] INTE_RESET = 16'h0000;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    // encodings
    localparam logic [1:0] TRIG_SOFTWARE = 2'h0;
    localparam logic [1:0] TRIG_TIMER = 2'h1;
    localparam logic [1:0] TRIG_RESERVED = 2'h2;
    localparam logic [1:0] TRIG_PIN = 2'h3;
    localparam logic [1:0] RANGE_ENABLED = 2'h3;
    localparam logic [3:0] SMP_BASE_CYCLES = 4'h4;
    localparam logic [2:0] LAST_INPUT = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        ACR_IDLE,
        ACR_ARMED,
        ACR_SYNC,
        ACR_SAMPLE,
        ACR_CONVERT,
        ACR_HALT
    } acr_state_type;
endpackage

// ==== verilog/acr_sync.sv ====
// two flip-flop synchroniser for one level from outside the clock domain
module acr_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // level in and out
    input wire logic asyncIn,
    output logic syncOut
);
    logic stage1;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule

// ==== verilog/acr_converter_control.sv ====
// control, status and result registers of one eight-input converter channel
// Contract
// [R1] busy reads 1 while converting, 0 when idle
// [R2] start=1 converts on software trigger, arms pin or timer trigger otherwise
// [R3] start bit never self-clears; software writes 0 then 1 to rerun
// [R4] start=0 lets the running conversion finish, then stops
// [R5] software holds start 1 one tick, 0 two ticks
// [R6] enable bit runs the unit and gates its operating clock
// [R7] enable reads 0 only after termination; software checks before clock off
// [R8] software changes select and range registers only while not busy
// [R9] first input at bits 10-8, last input at bits 13-11
// [R10] software keeps last input not below first input
// [R11] alignment 1 puts result at 15-4, 0 at 11-0
// [R12] alignment change reshapes every result read at once, data kept
// [R13] mode 1 continuous, mode 0 one pass over the range
// [R14] trigger code 3 pin, 1 timer underflow, 0 software, 2 reserved
// [R15] sampling lasts field plus four operating clock ticks
// [R16] conversions only with range code 3; code 0 blocks them
// [R17] overwrite flags 15-8, completion flags 7-0, cleared by writing 1
// [R18] triggers taken only when not busy, start synced to operating clock
// [R19] inputs converted ascending; one pass stops after last input
// [R20] overwrite flag sets on load while completion flag still set
// [R21] interrupt request only for a set flag with its enable
// [R22] result load and completion flag set in the same cycle
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
module acr_converter_control
    import acr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // axi4-lite register port
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // trigger sources
    input wire logic externalTriggerPin,
    input wire logic timerOperatingClock,
    input wire logic timerUnderflow,
    // analog converter core
    output logic coreClkEn,
    output logic coreSampling,
    output logic coreStart,
    output logic [2:0] currentInput,
    input wire logic coreDone,
    input wire logic [11:0] coreData,
    // interrupt request
    output logic convIrq
);
    // bus state
    logic awHave, wHave, next_awHave, next_wHave;
    logic [7:0] awAddr, next_awAddr;
    logic [15:0] wData, next_wData;
    logic [1:0] wStrb, next_wStrb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic wrEn;
    // registers
    logic enableReq, start, align, mode;
    logic next_enableReq, next_start, next_align, next_mode, next_enable;
    logic [2:0] firstIn, lastIn, smpSel, next_firstIn, next_lastIn, next_smpSel;
    logic [1:0] trigSrc, range, next_trigSrc, next_range;
    logic [15:0] flags, inte, next_flags, next_inte, flagSet, flagClr;
    logic [11:0] results [8];
    logic [11:0] next_results [8];
    logic next_convIrq;
    // sequencer
    acr_state_type state, next_state;
    logic [2:0] next_channel;
    logic [3:0] smpCount, next_smpCount;
    logic next_coreStart, next_coreSampling, load, busy, stopReq;
    // trigger edges
    logic extSync, extPrev, tmrSync, tmrPrev, extFall, tick;

    acr_sync u_ext_sync (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(externalTriggerPin),
        .syncOut(extSync)
    );

    acr_sync u_tmr_sync (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(timerOperatingClock),
        .syncOut(tmrSync)
    );

    assign extFall = extPrev & ~extSync;
    assign tick = tmrSync & ~tmrPrev;
    assign busy = (state == ACR_SYNC) || (state == ACR_SAMPLE) || (state == ACR_CONVERT); // R1
    assign stopReq = !start || !enableReq; // R4
    assign wrEn = awHave && wHave && !bvalid;

    function automatic logic [15:0] mergeLanes(input logic [15:0] old, input logic [15:0] data,
                                               input logic [1:0] strb);
        mergeLanes = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        logic [7:0] word;
        word = {addr[7:2], 2'b00};
        mapped = (word == CTL_OFFSET) || (word == TRG_OFFSET) || (word == CFG_OFFSET)
                 || (word == INTF_OFFSET) || (word == INTE_OFFSET)
                 || (addr[7:5] == RESULT_REGION);
    endfunction

    // bus handshakes and read data
    always_comb begin
        logic [15:0] rd;
        logic [7:0] word;
        rd = 16'h0000;
        word = {araddr[7:2], 2'b00};
        next_awHave = awHave;
        next_awAddr = awAddr;
        next_wHave = wHave;
        next_wData = wData;
        next_wStrb = wStrb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_arready = arready;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (awvalid && awready) begin
            next_awHave = 1'b1;
            next_awAddr = awaddr;
        end
        if (wvalid && wready) begin
            next_wHave = 1'b1;
            next_wData = wdata[15:0];
            next_wStrb = wstrb[1:0];
        end
        if (wrEn) begin
            next_awHave = 1'b0;
            next_wHave = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = mapped(awAddr) ? RESP_OKAY : RESP_DECERR;
        end else if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        next_awready = !next_awHave;
        next_wready = !next_wHave;
        if (araddr[7:5] == RESULT_REGION) begin
            // alignment applied on read, stored value untouched
            rd = align ? {results[araddr[4:2]], 4'h0} : {4'h0, results[araddr[4:2]]}; // R11 R12
        end else begin
            case (word)
                CTL_OFFSET: begin
                    rd = '0;
                    rd[CTL_STATUS_LSB +: 3] = currentInput;
                    rd[CTL_BUSY_BIT] = busy; // R1
                    rd[CTL_START_BIT] = start;
                    rd[CTL_ENABLE_BIT] = coreClkEn; // R7
                end
                TRG_OFFSET: begin
                    rd = '0;
                    rd[TRG_LAST_LSB +: 3] = lastIn;
                    rd[TRG_FIRST_LSB +: 3] = firstIn;
                    rd[TRG_ALIGN_BIT] = align;
                    rd[TRG_MODE_BIT] = mode;
                    rd[TRG_SRC_LSB +: 2] = trigSrc;
                    rd[TRG_SMP_LSB +: 3] = smpSel;
                end
                CFG_OFFSET: begin
                    rd = '0;
                    rd[CFG_RANGE_LSB +: 2] = range;
                end
                INTF_OFFSET: rd = flags; // R17
                INTE_OFFSET: rd = inte;
                default: rd = 16'h0000;
            endcase
        end
        if (arvalid && arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rdata = {16'h0000, rd};
            next_rresp = mapped(araddr) ? RESP_OKAY : RESP_DECERR;
        end else if (rvalid && rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            awHave <= 1'b0;
            awAddr <= 8'h00;
            wHave <= 1'b0;
            wData <= 16'h0000;
            wStrb <= 2'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else begin
            awHave <= next_awHave;
            awAddr <= next_awAddr;
            wHave <= next_wHave;
            wData <= next_wData;
            wStrb <= next_wStrb;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // register file, flags and results
    always_comb begin
        logic [15:0] merged;
        logic [7:0] word;
        merged = 16'h0000;
        word = {awAddr[7:2], 2'b00};
        next_enableReq = enableReq;
        next_start = start;
        next_firstIn = firstIn;
        next_lastIn = lastIn;
        next_align = align;
        next_mode = mode;
        next_trigSrc = trigSrc;
        next_smpSel = smpSel;
        next_range = range;
        next_inte = inte;
        flagClr = 16'h0000;
        flagSet = 16'h0000;
        next_results = results;
        if (wrEn) begin
            case (word)
                CTL_OFFSET: begin
                    merged = mergeLanes({14'h0000, start, enableReq}, wData, wStrb);
                    next_start = merged[CTL_START_BIT]; // R3
                    next_enableReq = merged[CTL_ENABLE_BIT];
                end
                TRG_OFFSET: begin
                    merged = mergeLanes({2'h0, lastIn, firstIn, align, mode, trigSrc, 1'b0,
                                         smpSel}, wData, wStrb);
                    next_lastIn = merged[TRG_LAST_LSB +: 3]; // R9
                    next_firstIn = merged[TRG_FIRST_LSB +: 3]; // R9
                    next_align = merged[TRG_ALIGN_BIT];
                    next_mode = merged[TRG_MODE_BIT];
                    next_trigSrc = merged[TRG_SRC_LSB +: 2];
                    next_smpSel = merged[TRG_SMP_LSB +: 3];
                end
                CFG_OFFSET: begin
                    merged = mergeLanes({14'h0000, range}, wData, wStrb);
                    next_range = merged[CFG_RANGE_LSB +: 2];
                end
                INTF_OFFSET: flagClr = mergeLanes(16'h0000, wData, wStrb); // R17
                INTE_OFFSET: next_inte = mergeLanes(inte, wData, wStrb);
                default: merged = 16'h0000;
            endcase
        end
        if (load) begin
            next_results[currentInput] = coreData; // R22
            flagSet[currentInput] = 1'b1; // R22
            flagSet[OVERWRITE_LSB + currentInput] = flags[currentInput]; // R20
        end
        // a set in the clearing cycle wins
        next_flags = (flags & ~flagClr) | flagSet; // R17
        // termination: enable reads 0 only once nothing is converting
        next_enable = enableReq || (coreClkEn && busy); // R6 R7
        next_convIrq = |(flags & inte); // R21
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enableReq <= ENABLE_RESET;
            coreClkEn <= ENABLE_RESET;
            start <= START_RESET;
            firstIn <= INPUT_RESET;
            lastIn <= INPUT_RESET;
            align <= ALIGN_RESET;
            mode <= MODE_RESET;
            trigSrc <= SRC_RESET;
            smpSel <= SMP_RESET;
            range <= RANGE_RESET;
            flags <= FLAGS_RESET;
            inte <= INTE_RESET;
            convIrq <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                results[i] <= RESULT_RESET;
            end
        end else begin
            enableReq <= next_enableReq;
            coreClkEn <= next_enable;
            start <= next_start;
            firstIn <= next_firstIn;
            lastIn <= next_lastIn;
            align <= next_align;
            mode <= next_mode;
            trigSrc <= next_trigSrc;
            smpSel <= next_smpSel;
            range <= next_range;
            flags <= next_flags;
            inte <= next_inte;
            convIrq <= next_convIrq;
            results <= next_results;
        end
    end

    // conversion sequencer
    always_comb begin
        next_state = state;
        next_channel = currentInput;
        next_smpCount = smpCount;
        next_coreStart = 1'b0;
        next_coreSampling = coreSampling;
        load = 1'b0;
        case (state)
            ACR_IDLE: begin
                if (enableReq && start && range == RANGE_ENABLED) begin // R16
                    next_channel = firstIn;
                    next_state = (trigSrc == TRIG_SOFTWARE) ? ACR_SYNC : ACR_ARMED; // R2 R14
                end
            end
            ACR_ARMED: begin
                if (stopReq) begin
                    next_state = ACR_IDLE;
                end else if ((trigSrc == TRIG_TIMER && timerUnderflow)
                             || (trigSrc == TRIG_PIN && extFall)) begin // R14 R18
                    next_channel = firstIn;
                    next_state = ACR_SYNC;
                end
            end
            ACR_SYNC: begin
                if (stopReq) begin
                    next_state = ACR_IDLE;
                end else if (tick) begin // R18
                    next_smpCount = {1'b0, smpSel} + SMP_BASE_CYCLES; // R15
                    next_coreSampling = 1'b1;
                    next_state = ACR_SAMPLE;
                end
            end
            ACR_SAMPLE: begin
                if (tick) begin
                    if (smpCount == 4'h1) begin
                        next_coreSampling = 1'b0;
                        next_coreStart = 1'b1;
                        next_state = ACR_CONVERT;
                    end else begin
                        next_smpCount = smpCount - 4'h1; // R15
                    end
                end
            end
            ACR_CONVERT: begin
                if (coreDone) begin
                    load = 1'b1;
                    if (stopReq || currentInput == lastIn) begin
                        if (currentInput == LAST_INPUT) begin
                            next_channel = 3'h0;
                        end
                        if (stopReq) begin
                            next_state = ACR_IDLE; // R4
                        end else if (mode) begin
                            next_channel = firstIn; // R13
                            next_state = ACR_SYNC;
                        end else begin
                            // one pass done; pin and timer stay armed
                            next_state = (trigSrc == TRIG_SOFTWARE) ? ACR_HALT : ACR_ARMED; // R19
                        end
                    end else begin
                        next_channel = currentInput + 3'h1; // R19
                        next_state = ACR_SYNC;
                    end
                end
            end
            ACR_HALT: begin
                if (stopReq) begin
                    next_state = ACR_IDLE; // R3
                end
            end
            default: next_state = ACR_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ACR_IDLE;
            currentInput <= INPUT_RESET;
            smpCount <= 4'h0;
            coreStart <= 1'b0;
            coreSampling <= 1'b0;
            extPrev <= 1'b0;
            tmrPrev <= 1'b0;
        end else begin
            state <= next_state;
            currentInput <= next_channel;
            smpCount <= next_smpCount;
            coreStart <= next_coreStart;
            coreSampling <= next_coreSampling;
            extPrev <= extSync;
            tmrPrev <= tmrSync;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_idle_not_busy;
        (state == ACR_IDLE || state == ACR_ARMED) |-> !busy;
    endproperty
    a_idle_not_busy: assert property (p_idle_not_busy) // R1
        else $error("busy shown while idle");

    property p_sw_start;
        (state == ACR_IDLE && enableReq && start && range == RANGE_ENABLED
         && trigSrc == TRIG_SOFTWARE) |=> (state == ACR_SYNC && currentInput == $past(firstIn));
    endproperty
    a_sw_start: assert property (p_sw_start) // R2
        else $error("software start did not begin a conversion");

    property p_start_kept;
        !wrEn |=> (start == $past(start));
    endproperty
    a_start_kept: assert property (p_start_kept) // R3
        else $error("start bit changed without a write");

    property p_finish_conv;
        (state == ACR_CONVERT && !coreDone) |=> (state == ACR_CONVERT);
    endproperty
    a_finish_conv: assert property (p_finish_conv) // R4
        else $error("conversion abandoned before completion");

    property p_enable_hold;
        busy |=> coreClkEn;
    endproperty
    a_enable_hold: assert property (p_enable_hold) // R7
        else $error("enable dropped during conversion");

    property p_sample_len;
        (state == ACR_SYNC && tick && !stopReq)
            |=> (smpCount == {1'b0, $past(smpSel)} + SMP_BASE_CYCLES) && coreSampling;
    endproperty
    a_sample_len: assert property (p_sample_len) // R15
        else $error("sampling count wrong");

    property p_range_block;
        (state == ACR_IDLE && range != RANGE_ENABLED) |=> (state == ACR_IDLE);
    endproperty
    a_range_block: assert property (p_range_block) // R16
        else $error("conversion started with range disabled");

    property p_ascend;
        (state == ACR_CONVERT && coreDone && !stopReq && currentInput != lastIn)
            |=> (currentInput == $past(currentInput) + 3'h1) && state == ACR_SYNC;
    endproperty
    a_ascend: assert property (p_ascend) // R19
        else $error("inputs not converted in ascending order");

    property p_load_flag;
        (state == ACR_CONVERT && coreDone)
            |=> flags[$past(currentInput)] && results[$past(currentInput)] == $past(coreData);
    endproperty
    a_load_flag: assert property (p_load_flag) // R22
        else $error("result load without completion flag");

    property p_overwrite;
        (state == ACR_CONVERT && coreDone && flags[currentInput])
            |=> flags[{1'b1, $past(currentInput)}];
    endproperty
    a_overwrite: assert property (p_overwrite) // R20
        else $error("overwrite flag not set");

    property p_irq;
        ##1 (convIrq == |($past(flags) & $past(inte)));
    endproperty
    a_irq: assert property (p_irq) // R21
        else $error("interrupt request disagrees with flags and enables");
endmodule

// ==== verif/acr_core_model.sv ====
// converter core and timer clock stand-in
module acr_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // core link
    input wire logic coreStart,
    output logic coreDone,
    output logic [11:0] coreData,
    output logic timerOperatingClock
);
    timeunit 1ns;
    timeprecision 1ns;
    int seed = 32'hadf9;
    int left = 0;
    logic [1:0] div = 2'h0;
    // data changes every cycle, valid only with done
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            coreDone <= 1'b0;
            timerOperatingClock <= 1'b0;
            left = 0;
        end else begin
            div <= div + 2'h1;
            timerOperatingClock <= div[1];
            coreData <= 12'($random(seed));
            coreDone <= left == 1;
            if (coreStart === 1'b1) left = 2 + ($random(seed) & 7);
            else if (left > 0) left--;
        end
    end
endmodule

// ==== verif/test_acr_converter_control.sv ====
// self-checking bench of the converter control block
module test_acr_converter_control
    import acr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h3;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic externalTriggerPin = 1'b1;
    logic timerUnderflow = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, coreClkEn, coreSampling, coreStart;
    logic coreDone, timerOperatingClock, convIrq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] currentInput;
    logic [11:0] coreData;
    logic [15:0] flags = 16'h0;
    logic [11:0] res [8] = '{default: 12'h000};
    logic [11:0] got [$];
    int errTotal = 0;
    int nChecks = 0;
    int seed = 32'hadf9;
    initial forever #10 clk = ~clk;
    acr_converter_control uut (.clk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .externalTriggerPin, .timerOperatingClock, .timerUnderflow,
        .coreClkEn, .coreSampling, .coreStart, .currentInput, .coreDone, .coreData, .convIrq);
    acr_core_model core (.clk, .rst_b, .coreStart, .coreDone, .coreData, .timerOperatingClock);
    always @(posedge clk) if (coreDone === 1'b1) got.push_back(coreData);
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        nChecks++;
        if (a !== e) begin
            errTotal++;
            $display("unexpected at %0t: got %h want %h", $time, a, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (100) begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        chk(bresp, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] r, output logic [31:0] v);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (100) begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        v = rdata;
        rready <= 1'b0;
        chk(rresp, r);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, RESP_OKAY, v);
        chk(v, e);
    endtask
    task automatic run(input logic [1:0] src, input int f, input int l, input logic [1:0] rng,
                       input bit m);
        logic [31:0] v;
        bit go;
        int t;
        int k;
        go = rng == RANGE_ENABLED && src != TRIG_RESERVED;
        t = l * 2048 + f * 256 + m * 64 + src * 16 + 7;
        wr(TRG_OFFSET, 16'(t), RESP_OKAY);
        wr(CFG_OFFSET, {14'h0, rng}, RESP_OKAY);
        wr(CTL_OFFSET, 16'h0001, RESP_OKAY);
        repeat (10) @(posedge clk);
        wr(CTL_OFFSET, 16'h0003, RESP_OKAY);
        timerUnderflow <= src == TRIG_TIMER;
        externalTriggerPin <= src != TRIG_PIN;
        @(posedge clk);
        timerUnderflow <= 1'b0;
        repeat (4) @(posedge clk);
        externalTriggerPin <= 1'b1;
        rd(CTL_OFFSET, RESP_OKAY, v);
        chk(v[10], go);
        chk(coreSampling, go);
        chk(coreClkEn, 1'b1);
        if (m) begin
            // let the range wrap at least once, then stop mid-run
            repeat (700) @(posedge clk);
            wr(CTL_OFFSET, 16'h0001, RESP_OKAY);
        end
        for (int n = 0; n < 300 && v[10] !== 1'b0; n++) rd(CTL_OFFSET, RESP_OKAY, v);
        k = 0;
        for (int i = f; got.size() > 0; i = i == l ? f : i + 1) begin
            if (flags[i]) flags[i + 8] = 1'b1;
            flags[i] = 1'b1;
            res[i] = got.pop_front();
            k++;
        end
        if (!m) chk(k, go ? l - f + 1 : 0);
        rc(INTF_OFFSET, {16'h0, flags});
        for (int al = 0; al < 2; al++) begin
            wr(TRG_OFFSET, 16'(t + al * 128), RESP_OKAY);
            for (int i = 0; i < 8; i++)
                rc(RESULT_BASE + 8'(4 * i), al ? {res[i], 4'h0} : res[i]);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        logic [31:0] v;
        int f;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        rc(CTL_OFFSET, 32'h0);
        rc(TRG_OFFSET, 32'h7);
        rc(CFG_OFFSET, 32'h0);
        rc(INTF_OFFSET, 32'h0);
        rd(8'h40, RESP_DECERR, v);
        chk(v, 32'h0);
        wr(8'h44, 16'hffff, RESP_DECERR);
        f = $random(seed) & 7;
        run(TRIG_SOFTWARE, f, 7, RANGE_ENABLED, 1'b0);
        run(TRIG_SOFTWARE, f, 7, RANGE_ENABLED, 1'b0);
        run(TRIG_SOFTWARE, f, 7, RANGE_ENABLED, 1'b1);
        wr(INTE_OFFSET, 16'hffff, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk(convIrq, 1'b1);
        wr(INTF_OFFSET, 16'hffff, RESP_OKAY);
        flags = 16'h0;
        rc(INTF_OFFSET, 32'h0);
        chk(convIrq, 1'b0);
        run(TRIG_TIMER, 0, f, RANGE_ENABLED, 1'b0);
        run(TRIG_PIN, f, f, RANGE_ENABLED, 1'b0);
        run(TRIG_RESERVED, 0, 7, RANGE_ENABLED, 1'b0);
        run(TRIG_SOFTWARE, 0, 3, 2'h0, 1'b0);
        wr(CTL_OFFSET, 16'h0000, RESP_OKAY);
        rc(CTL_OFFSET, 32'h0);
        chk(coreClkEn, 1'b0);
        end_of_test();
    end
    initial begin
        repeat (40000) @(posedge clk);
        errTotal++;
        end_of_test();
    end
endmodule
